// ===== include/eag_defines.svh
// constants of the effective address generator
// Function
// - eleven forms: register, immediate, nine memory
// - register or immediate operand source
// - address is base plus scaled index plus displacement
// - linear is segment base plus address
// - scale factor only 1, 2, 4, 8
// - 32-bit: any base, index never stack pointer
// - 32-bit: 8 or 32-bit displacement, extended
// - 16-bit: 8/16 displacement, legacy base/index registers
// - base plus index costs one extra clock
// - code descriptor size bit picks default size
// - real mode defaults to 16 bits
// - size prefixes invert default for one instruction
// - real mode address above ffff faults
// - real mode base is selector shifted four
`ifndef EAG_DEFINES_SVH
`define EAG_DEFINES_SVH
`define EAG_OFS_CTRL 8'h00
`define EAG_OFS_STATUS 8'h04
`define EAG_OFS_MASK 8'h08
`define EAG_OFS_LAST_EA 8'h0c
`define EAG_OFS_LAST_LIN 8'h10
`define EAG_CTRL_REAL 0
`define EAG_CTRL_DBIT 1
`define EAG_ST_DONE 0
`define EAG_ST_FAULT 1
`define EAG_ST_BAD 2
`define EAG_CTRL_RESET 2'h1
`define EAG_MASK_RESET 3'h0
`define EAG_REG_BX 3'h3
`define EAG_REG_SP 3'h4
`define EAG_REG_BP 3'h5
`define EAG_REG_SI 3'h6
`define EAG_REG_DI 3'h7
`define EAG_REAL_SHIFT 4
`define EAG_REAL_LIMIT 32'h0000ffff
`define EAG_BI_EXTRA_CYC 1
`endif

// ===== include/eag_pkg.sv
// types of the effective address generator
package eag_pkg;
    typedef enum logic [3:0] {
        EAG_F_REG = 4'h0,
        EAG_F_IMM = 4'h1,
        EAG_F_DIRECT = 4'h2,
        EAG_F_REG_IND = 4'h3,
        EAG_F_BASED = 4'h4,
        EAG_F_INDEX = 4'h5,
        EAG_F_SC_INDEX = 4'h6,
        EAG_F_B_INDEX = 4'h7,
        EAG_F_B_SC_INDEX = 4'h8,
        EAG_F_B_INDEX_D = 4'h9,
        EAG_F_B_SC_INDEX_D = 4'ha
    } eag_form_t;
    typedef enum logic [1:0] {EAG_D_NONE = 2'h0, EAG_D_BYTE = 2'h1, EAG_D_WIDE = 2'h2} eag_disp_t;
    typedef enum logic [1:0] {EAG_W_8 = 2'h0, EAG_W_16 = 2'h1, EAG_W_32 = 2'h2} eag_width_t;
    typedef struct packed {
        eag_form_t form;
        logic [2:0] base_sel;
        logic [2:0] index_sel;
        logic [1:0] scale_log2;
        eag_disp_t disp_kind;
        logic [31:0] disp;
        logic [2:0] opnd_sel;
        eag_width_t opnd_width;
        logic [31:0] imm;
        logic [15:0] seg_sel;
        logic [31:0] seg_base;
        logic op_prefix;
        logic addr_prefix;
    } eag_req_t;
    function automatic logic uses_base(eag_form_t f);
        return f inside {EAG_F_REG_IND, EAG_F_BASED, EAG_F_B_INDEX, EAG_F_B_SC_INDEX,
            EAG_F_B_INDEX_D, EAG_F_B_SC_INDEX_D};
    endfunction
    function automatic logic uses_index(eag_form_t f);
        return f inside {EAG_F_INDEX, EAG_F_SC_INDEX, EAG_F_B_INDEX, EAG_F_B_SC_INDEX,
            EAG_F_B_INDEX_D, EAG_F_B_SC_INDEX_D};
    endfunction
    function automatic logic is_scaled(eag_form_t f);
        return f inside {EAG_F_SC_INDEX, EAG_F_B_SC_INDEX, EAG_F_B_SC_INDEX_D};
    endfunction
    function automatic logic is_mem(eag_form_t f);
        return !(f inside {EAG_F_REG, EAG_F_IMM});
    endfunction
endpackage

// ===== src/eag_size_sel.sv
// default and overridden operand and address size
`timescale 1ns/10ps
module eag_size_sel (
    input wire logic real_mode, // real mode active
    input wire logic d_bit, // code descriptor size bit
    input wire logic op_prefix, // operand-size prefix present
    input wire logic addr_prefix, // address-length prefix present
    output logic op32, // operands are 32 bits
    output logic addr32 // addresses are 32 bits
);
    logic def32;
    assign def32 = d_bit & ~real_mode;
    assign op32 = def32 ^ op_prefix;
    assign addr32 = def32 ^ addr_prefix;
endmodule

// ===== src/eag_addr_calc.sv
// effective address adder with register legality checks
`timescale 1ns/10ps
`include "eag_defines.svh"
module eag_addr_calc (
    input eag_pkg::eag_req_t req, // decoded request
    input wire logic [7:0][31:0] regs, // general registers
    input wire logic addr32, // active address size is 32
    output logic [31:0] ea, // truncated effective address
    output logic bad // illegal register or scale use
);
    logic base_ok, index_ok, sc_bad;
    logic [31:0] base_v, index_v, disp_v, sum;
    logic [1:0] sh;
    always_comb begin
        base_ok = addr32 || req.base_sel == `EAG_REG_BX
            || req.base_sel == `EAG_REG_BP;
        index_ok = addr32 ? (req.index_sel != `EAG_REG_SP)
            : (req.index_sel == `EAG_REG_SI || req.index_sel == `EAG_REG_DI);
        // legacy model has no scaling
        sc_bad = !addr32 && eag_pkg::is_scaled(req.form) && req.scale_log2 != 2'h0;
        base_v = (eag_pkg::uses_base(req.form) && base_ok) ? regs[req.base_sel] : 32'h0;
        index_v = (eag_pkg::uses_index(req.form) && index_ok) ? regs[req.index_sel] : 32'h0;
        sh = (eag_pkg::is_scaled(req.form) && addr32) ? req.scale_log2 : 2'h0;
        case (req.disp_kind)
            eag_pkg::EAG_D_BYTE: disp_v = {{24{req.disp[7]}}, req.disp[7:0]};
            eag_pkg::EAG_D_WIDE: disp_v = addr32 ? req.disp
                : {{16{req.disp[15]}}, req.disp[15:0]};
            default: disp_v = 32'h0;
        endcase
        sum = base_v + (index_v << sh) + disp_v;
        ea = addr32 ? sum : {16'h0, sum[15:0]};
        bad = eag_pkg::is_mem(req.form) && ((eag_pkg::uses_base(req.form) && !base_ok)
            || (eag_pkg::uses_index(req.form) && !index_ok) || sc_bad);
    end
endmodule

// ===== src/eag_top.sv
// effective address generator: operand select, address add, size control
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/10ps
`include "eag_defines.svh"
module eag_top (
    input wire logic CLOCK, // core clock
    input wire logic RESET, // synchronous, active high
    input wire logic REQ_VALID, // decoder offers a request
    output logic REQ_READY, // generator takes the request
    input eag_pkg::eag_req_t REQ, // decoded operand request
    input wire logic [7:0][31:0] REGS, // general register file view
    output logic RES_VALID, // one-cycle result pulse
    output logic [31:0] RES_OPERAND, // register or immediate operand
    output logic [31:0] RES_EA, // effective address
    output logic [31:0] RES_LINEAR, // linear address
    output logic RES_OP32, // operand size of the instruction
    output logic RES_ADDR32, // address size of the instruction
    output logic RES_GP_FAULT, // real mode limit fault
    output logic RES_BAD, // illegal register or scale
    input wire logic [7:0] BUS_ADDR, // register address
    input wire logic [31:0] BUS_WDATA, // write data
    input wire logic BUS_WR, // write strobe
    input wire logic BUS_RD, // read strobe
    output logic [31:0] BUS_RDATA, // read data, cycle after strobe
    output logic IRQ // level interrupt
);
    typedef enum logic [1:0] {S_IDLE = 2'b01, S_EXTRA = 2'b10} eag_state_t;

    ////////////////////////////////////////////////////////////////////////////
    // control register and size selection
    logic [1:0] ctrl;
    logic [2:0] status, mask;
    logic real_mode, d_bit;
    assign real_mode = ctrl[`EAG_CTRL_REAL];
    assign d_bit = ctrl[`EAG_CTRL_DBIT];

    eag_state_t state;
    eag_pkg::eag_req_t hold, cur;
    logic accept, both_used;
    logic op32, addr32;
    logic [31:0] ea;
    logic bad;

    // the hold copy drives the adder during the extra clock
    assign cur = (state == S_EXTRA) ? hold : REQ;

    eag_size_sel u_size (
        .real_mode(real_mode),
        .d_bit(d_bit),
        .op_prefix(cur.op_prefix),
        .addr_prefix(cur.addr_prefix),
        .op32(op32),
        .addr32(addr32)
    );

    eag_addr_calc u_calc (
        .req(cur),
        .regs(REGS),
        .addr32(addr32),
        .ea(ea),
        .bad(bad)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencing
    assign REQ_READY = (state == S_IDLE);
    assign accept = REQ_VALID && REQ_READY;
    assign both_used = eag_pkg::uses_base(REQ.form) && eag_pkg::uses_index(REQ.form);

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            state <= S_IDLE;
        end else begin
            case (state)
                S_IDLE: begin
                    if (accept && both_used) begin
                        state <= S_EXTRA;
                    end
                end
                S_EXTRA: begin
                    state <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            hold <= '0;
        end else if (accept) begin
            hold <= REQ;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result formation
    logic finish;
    logic [31:0] next_linear, next_operand, raw_opnd;
    logic [3:0] hi_nib;
    logic next_fault;
    assign finish = (accept && !both_used) || state == S_EXTRA;

    always_comb begin
        hi_nib = 4'h0;
        if (real_mode) begin
            next_linear = {12'h0, cur.seg_sel, hi_nib} + ea;
        end else begin
            next_linear = cur.seg_base + ea;
        end
        // prefix widens the forms only, never the real mode range
        next_fault = real_mode && eag_pkg::is_mem(cur.form) && ea > `EAG_REAL_LIMIT;
        raw_opnd = (cur.form == eag_pkg::EAG_F_IMM) ? cur.imm : REGS[cur.opnd_sel];
        case (cur.opnd_width)
            // byte registers 4..7 are the high bytes of 0..3
            eag_pkg::EAG_W_8: begin
                if (cur.form == eag_pkg::EAG_F_REG && cur.opnd_sel[2]) begin
                    next_operand = {24'h0, REGS[{1'b0, cur.opnd_sel[1:0]}][15:8]};
                end else begin
                    next_operand = {24'h0, raw_opnd[7:0]};
                end
            end
            eag_pkg::EAG_W_16: next_operand = {16'h0, raw_opnd[15:0]};
            default: next_operand = op32 ? raw_opnd : {16'h0, raw_opnd[15:0]};
        endcase
        if (eag_pkg::is_mem(cur.form)) begin
            next_operand = 32'h0;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            RES_VALID <= 1'b0;
        end else begin
            RES_VALID <= finish;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            RES_OPERAND <= 32'h0;
            RES_EA <= 32'h0;
            RES_LINEAR <= 32'h0;
            RES_OP32 <= 1'b0;
            RES_ADDR32 <= 1'b0;
            RES_GP_FAULT <= 1'b0;
            RES_BAD <= 1'b0;
        end else if (finish) begin
            RES_OPERAND <= next_operand;
            RES_EA <= eag_pkg::is_mem(cur.form) ? ea : 32'h0;
            RES_LINEAR <= eag_pkg::is_mem(cur.form) ? next_linear : 32'h0;
            RES_OP32 <= op32;
            RES_ADDR32 <= addr32;
            RES_GP_FAULT <= next_fault;
            RES_BAD <= bad;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status, mask and interrupt
    logic [2:0] events, w1c;
    assign events = {finish && bad, finish && next_fault, finish};
    assign w1c = (BUS_WR && BUS_ADDR == `EAG_OFS_STATUS) ? BUS_WDATA[2:0] : 3'h0;

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            status <= 3'h0;
        end else begin
            // a new event wins over a clear in the same cycle
            status <= (status & ~w1c) | events;
        end
    end

    assign IRQ = |(status & mask);

    ////////////////////////////////////////////////////////////////////////////
    // register port
    logic [31:0] last_ea, last_lin;
    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            last_ea <= 32'h0;
            last_lin <= 32'h0;
        end else if (finish && eag_pkg::is_mem(cur.form)) begin
            last_ea <= ea;
            last_lin <= next_linear;
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            ctrl <= `EAG_CTRL_RESET;
            mask <= `EAG_MASK_RESET;
        end else if (BUS_WR) begin
            if (BUS_ADDR == `EAG_OFS_CTRL) begin
                ctrl <= BUS_WDATA[1:0];
            end else if (BUS_ADDR == `EAG_OFS_MASK) begin
                mask <= BUS_WDATA[2:0];
            end
        end
    end

    always_ff @(posedge CLOCK) begin
        if (RESET) begin
            BUS_RDATA <= 32'h0;
        end else if (BUS_RD) begin
            if (BUS_ADDR == `EAG_OFS_CTRL) begin
                BUS_RDATA <= {30'h0, ctrl};
            end else if (BUS_ADDR == `EAG_OFS_STATUS) begin
                BUS_RDATA <= {29'h0, status};
            end else if (BUS_ADDR == `EAG_OFS_MASK) begin
                BUS_RDATA <= {29'h0, mask};
            end else if (BUS_ADDR == `EAG_OFS_LAST_EA) begin
                BUS_RDATA <= last_ea;
            end else if (BUS_ADDR == `EAG_OFS_LAST_LIN) begin
                BUS_RDATA <= last_lin;
            end else begin
                BUS_RDATA <= 32'h0;
            end
        end else begin
            BUS_RDATA <= 32'h0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RESET);

    logic h_mem, h_addr32;
    assign h_mem = eag_pkg::is_mem(hold.form);
    assign h_addr32 = (d_bit & ~real_mode) ^ hold.addr_prefix;

    property p_lat_single;
        accept && !both_used |=> RES_VALID;
    endproperty
    a_lat_single: assert property (p_lat_single) else $error("single form late");

    property p_lat_both;
        accept && both_used |=> !RES_VALID ##1 RES_VALID;
    endproperty
    a_lat_both: assert property (p_lat_both) else $error("base plus index latency");

    property p_busy_extra;
        state == S_EXTRA |-> !REQ_READY ##1 REQ_READY;
    endproperty
    a_busy_extra: assert property (p_busy_extra) else $error("extra clock length");

    property p_real_lin;
        RES_VALID && h_mem && real_mode && $stable(ctrl)
            |-> RES_LINEAR == {12'h0, hold.seg_sel, 4'h0} + RES_EA;
    endproperty
    a_real_lin: assert property (p_real_lin) else $error("real linear wrong");

    property p_prot_lin;
        RES_VALID && h_mem && !real_mode && $stable(ctrl)
            |-> RES_LINEAR == hold.seg_base + RES_EA;
    endproperty
    a_prot_lin: assert property (p_prot_lin) else $error("linear wrong");

    property p_fault;
        RES_VALID && h_mem && real_mode && $stable(ctrl)
            |-> RES_GP_FAULT == (RES_EA[31:16] != 16'h0);
    endproperty
    a_fault: assert property (p_fault) else $error("limit fault wrong");

    property p_trunc;
        RES_VALID && !RES_ADDR32 |-> RES_EA[31:16] == 16'h0;
    endproperty
    a_trunc: assert property (p_trunc) else $error("16-bit address not cut");

    property p_size;
        RES_VALID && $stable(ctrl) |-> RES_ADDR32 == h_addr32
            && RES_OP32 == ((d_bit & ~real_mode) ^ hold.op_prefix);
    endproperty
    a_size: assert property (p_size) else $error("size selection wrong");

    property p_imm;
        RES_VALID && hold.form == eag_pkg::EAG_F_IMM && hold.opnd_width == eag_pkg::EAG_W_16
            |-> RES_OPERAND == {16'h0, hold.imm[15:0]};
    endproperty
    a_imm: assert property (p_imm) else $error("immediate operand wrong");

    property p_sticky;
        finish |=> status[`EAG_ST_DONE];
    endproperty
    a_sticky: assert property (p_sticky) else $error("done not set");

    property p_rdata_idle;
        !BUS_RD |=> BUS_RDATA == 32'h0;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its cycle");

    property p_done_clear;
        w1c[`EAG_ST_DONE] && !finish |=> !status[`EAG_ST_DONE];
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("done not cleared");

    property p_fault_sticky;
        finish && next_fault |=> status[`EAG_ST_FAULT];
    endproperty
    a_fault_sticky: assert property (p_fault_sticky) else $error("fault not kept");

    // outside real mode the limit never applies
    property p_pm_fault;
        RES_VALID && !real_mode && $stable(ctrl) |-> !RES_GP_FAULT;
    endproperty
    a_pm_fault: assert property (p_pm_fault) else $error("fault outside real mode");

    property p_nonmem_zero;
        RES_VALID && !h_mem |-> RES_EA == 32'h0 && RES_LINEAR == 32'h0;
    endproperty
    a_nonmem_zero: assert property (p_nonmem_zero) else $error("address on operand");

    property p_sp_index;
        RES_VALID && h_mem && h_addr32 && $stable(ctrl) && eag_pkg::uses_index(hold.form)
            && hold.index_sel == `EAG_REG_SP |-> RES_BAD;
    endproperty
    a_sp_index: assert property (p_sp_index) else $error("stack pointer index taken");

    property p_legacy_base;
        RES_VALID && h_mem && !h_addr32 && $stable(ctrl) && eag_pkg::uses_base(hold.form)
            && hold.base_sel != `EAG_REG_BX && hold.base_sel != `EAG_REG_BP |-> RES_BAD;
    endproperty
    a_legacy_base: assert property (p_legacy_base) else $error("legacy base taken");

    property p_scale16;
        RES_VALID && h_mem && !h_addr32 && $stable(ctrl) && eag_pkg::is_scaled(hold.form)
            && hold.scale_log2 != 2'h0 |-> RES_BAD;
    endproperty
    a_scale16: assert property (p_scale16) else $error("scale in 16-bit form");

    // results hold until the next pulse
    property p_res_hold;
        !finish |=> $stable(RES_EA) && $stable(RES_LINEAR) && $stable(RES_OPERAND);
    endproperty
    a_res_hold: assert property (p_res_hold) else $error("result moved");

    c_single: cover property (accept && !both_used ##1 RES_VALID);
    c_both: cover property (accept && both_used ##2 RES_VALID);
    c_fault: cover property (RES_VALID && RES_GP_FAULT);
    c_irq: cover property (IRQ);
    c_bad: cover property (RES_VALID && RES_BAD);
endmodule

// ===== verification/eag_dec_model.sv
// decoder-side model that offers operand requests to the generator
`timescale 1ns/10ps
module eag_dec_model (
    input wire logic clock, // core clock
    input wire logic reset, // synchronous, active high
    input wire logic offer, // bench has a request to send
    input eag_pkg::eag_req_t offer_req, // request to send next
    input wire logic req_ready, // generator takes the request
    output logic req_valid, // request offered
    output eag_pkg::eag_req_t req // request fields
);
    ////////////////////////////////////////
    // held until taken; idle fields flip every cycle so a stale request never looks good
    always_ff @(posedge clock) begin
        if (reset) begin
            req_valid <= 1'b0;
            req <= '0;
        end else if (offer && (!req_valid || req_ready)) begin
            req_valid <= 1'b1;
            req <= offer_req;
        end else if (!req_valid || req_ready) begin
            req_valid <= 1'b0;
            req <= ~req;
        end
    end
endmodule

// ===== verification/effective_address_generator_test.sv
// self-checking bench of the effective address generator
`timescale 1ns/10ps
`include "eag_defines.svh"
module effective_address_generator_test;
    typedef struct packed {
        logic [1:0] ctl; // d bit, real mode
        logic [1:0] pfx; // operand prefix, address prefix
        logic [3:0] form;
        logic [2:0] base;
        logic [2:0] idx;
        logic [1:0] sc;
        logic [1:0] dk;
        logic [31:0] disp; // also the immediate
        logic [2:0] sel;
        logic [1:0] w;
        logic [31:0] exp; // operand or effective address
        logic [3:0] flg; // bad, fault, addr32, op32
    } eag_row_t;
    localparam eag_row_t rows [23] = '{
        '{2'h2,2'h0,4'h0,3'h0,3'h0,2'h0,2'h0,32'h0,3'h2,2'h2,32'h300,4'h3},
        '{2'h2,2'h0,4'h0,3'h0,3'h0,2'h0,2'h0,32'h0,3'h5,2'h0,32'h2,4'h3},
        '{2'h2,2'h2,4'h1,3'h0,3'h0,2'h0,2'h0,32'hdeadbeef,3'h0,2'h2,32'hbeef,4'h2},
        '{2'h2,2'h0,4'h2,3'h0,3'h0,2'h0,2'h1,32'h80,3'h0,2'h2,32'hffffff80,4'h3},
        '{2'h2,2'h0,4'h3,3'h1,3'h0,2'h0,2'h0,32'h0,3'h0,2'h2,32'h200,4'h3},
        '{2'h2,2'h0,4'h4,3'h2,3'h0,2'h0,2'h2,32'h12345678,3'h0,2'h2,32'h12345978,4'h3},
        '{2'h2,2'h0,4'h5,3'h0,3'h3,2'h0,2'h1,32'h10,3'h0,2'h2,32'h410,4'h3},
        '{2'h2,2'h0,4'h6,3'h0,3'h1,2'h3,2'h0,32'h0,3'h0,2'h2,32'h1000,4'h3},
        '{2'h2,2'h0,4'h7,3'h0,3'h1,2'h3,2'h0,32'h0,3'h0,2'h2,32'h300,4'h3},
        '{2'h2,2'h0,4'h8,3'h5,3'h6,2'h1,2'h0,32'h0,3'h0,2'h2,32'h1400,4'h3},
        '{2'h2,2'h0,4'h9,3'h4,3'h7,2'h0,2'h2,32'hfffffff0,3'h0,2'h2,32'hcf0,4'h3},
        '{2'h2,2'h0,4'ha,3'h7,3'h2,2'h2,2'h1,32'h7f,3'h0,2'h2,32'h147f,4'h3},
        '{2'h2,2'h0,4'h5,3'h0,3'h4,2'h0,2'h1,32'h4,3'h0,2'h2,32'h4,4'hb},
        '{2'h0,2'h0,4'h4,3'h3,3'h0,2'h0,2'h2,32'hfffe,3'h0,2'h2,32'h3fe,4'h0},
        '{2'h0,2'h0,4'h7,3'h5,3'h7,2'h0,2'h0,32'h0,3'h0,2'h2,32'he00,4'h0},
        '{2'h0,2'h0,4'h4,3'h0,3'h0,2'h0,2'h1,32'h1,3'h0,2'h2,32'h1,4'h8},
        '{2'h0,2'h1,4'h6,3'h0,3'h6,2'h0,2'h0,32'h0,3'h0,2'h2,32'h700,4'h2},
        '{2'h3,2'h0,4'h4,3'h3,3'h0,2'h0,2'h2,32'h10,3'h0,2'h2,32'h410,4'h0},
        '{2'h3,2'h1,4'h2,3'h0,3'h0,2'h0,2'h2,32'h10000,3'h0,2'h2,32'h10000,4'h6},
        '{2'h3,2'h1,4'h2,3'h0,3'h0,2'h0,2'h2,32'hffff,3'h0,2'h2,32'hffff,4'h2},
        '{2'h2,2'h0,4'h1,3'h0,3'h0,2'h0,2'h0,32'h12345678,3'h0,2'h1,32'h5678,4'h3},
        '{2'h2,2'h0,4'h1,3'h0,3'h0,2'h0,2'h0,32'h1234,3'h0,2'h0,32'h34,4'h3},
        '{2'h0,2'h0,4'h6,3'h0,3'h6,2'h1,2'h0,32'h0,3'h0,2'h2,32'h700,4'h8}
    };
    logic clock, reset, offer, req_valid, req_ready, res_valid, res_op32, res_addr32;
    logic res_gp_fault, res_bad, bus_wr, bus_rd, irq;
    eag_pkg::eag_req_t offer_req, req;
    logic [7:0][31:0] regs;
    logic [31:0] res_operand, res_ea, res_linear, bus_wdata, bus_rdata, v;
    logic [7:0] bus_addr;
    int n_mismatch, checked, cycles, n;

    eag_dec_model i_eag_dec_model (.clock(clock), .reset(reset), .offer(offer),
        .offer_req(offer_req), .req_ready(req_ready), .req_valid(req_valid), .req(req));
    eag_top i_eag_top (.CLOCK(clock), .RESET(reset), .REQ_VALID(req_valid),
        .REQ_READY(req_ready), .REQ(req), .REGS(regs), .RES_VALID(res_valid),
        .RES_OPERAND(res_operand), .RES_EA(res_ea), .RES_LINEAR(res_linear),
        .RES_OP32(res_op32), .RES_ADDR32(res_addr32), .RES_GP_FAULT(res_gp_fault),
        .RES_BAD(res_bad), .BUS_ADDR(bus_addr), .BUS_WDATA(bus_wdata), .BUS_WR(bus_wr),
        .BUS_RD(bus_rd), .BUS_RDATA(bus_rdata), .IRQ(irq));
    ////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask
    task automatic results();
        $display("comparisons %0d, mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        @(posedge clock);
        bus_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        bus_addr <= a;
        bus_rd <= 1'b1;
        @(posedge clock);
        bus_rd <= 1'b0;
        #1 d = bus_rdata;
    endtask
    function automatic eag_pkg::eag_req_t mkreq(input eag_row_t r);
        eag_pkg::eag_req_t q;
        q = '0;
        q.form = eag_pkg::eag_form_t'(r.form);
        q.base_sel = r.base;
        q.index_sel = r.idx;
        q.scale_log2 = r.sc;
        q.disp_kind = eag_pkg::eag_disp_t'(r.dk);
        q.disp = r.disp;
        q.imm = r.disp;
        q.opnd_sel = r.sel;
        q.opnd_width = eag_pkg::eag_width_t'(r.w);
        q.seg_sel = 16'h1234;
        q.seg_base = 32'h00010000;
        {q.op_prefix, q.addr_prefix} = r.pfx;
        return q;
    endfunction
    task automatic expect_res(input eag_row_t r);
        logic [31:0] lin, f;
        bit mem;
        mem = r.form > 4'h1;
        lin = (r.ctl[0] ? {12'h000, 16'h1234, 4'h0} : 32'h00010000) + r.exp;
        if (!mem) lin = 32'h0;
        f = {28'h0, res_bad, res_gp_fault, res_addr32, res_op32};
        chk("valid", {31'h0, res_valid}, 32'h1);
        chk("operand", res_operand, mem ? 32'h0 : r.exp);
        chk("ea", res_ea, mem ? r.exp : 32'h0);
        chk("linear", res_linear, lin);
        chk("flags", f, {28'h0, r.flg});
    endtask
    task automatic run_row(input eag_row_t r);
        bit bi;
        bi = r.form > 4'h6;
        wr(`EAG_OFS_CTRL, {30'h0, r.ctl});
        @(posedge clock);
        offer <= 1'b1;
        offer_req <= mkreq(r);
        @(posedge clock);
        offer <= 1'b0;
        n = 0;
        do begin
            @(posedge clock);
            #1 n++;
            if (n == 1) chk("ready", {31'h0, req_ready}, {31'h0, !bi});
        end while (res_valid !== 1'b1 && n < 8);
        chk("latency", n, bi ? 32'h2 : 32'h1);
        expect_res(r);
    endtask
    ////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // ceiling well above the fewer than two hundred cycles the tests need
    always @(posedge clock) begin
        cycles++;
        if (cycles == 4000) begin
            n_mismatch++;
            results();
        end
    end
    initial begin
        {reset, offer, offer_req, bus_addr, bus_wdata, bus_wr, bus_rd} = '0;
        reset = 1'b1;
        for (int i = 0; i < 8; i++) regs[i] = 32'h100 * (i + 1);
        repeat (10) @(posedge clock);
        reset <= 1'b0;
        #1 chk("reset flags", {29'h0, req_ready, res_valid, irq}, 32'h4);
        chk("reset data", res_ea | res_linear | res_operand, 32'h0);
        rd(`EAG_OFS_CTRL, v);
        chk("ctrl", v, {30'h0, `EAG_CTRL_RESET});
        rd(`EAG_OFS_MASK, v);
        chk("mask", v, 32'h0);
        rd(`EAG_OFS_STATUS, v);
        chk("status", v, 32'h0);
        rd(8'h40, v);
        chk("unmapped", v, 32'h0);
        $display("test reset done");
        foreach (rows[i]) run_row(rows[i]);
        $display("test table done");
        // base plus index then two singles, offered back to back
        wr(`EAG_OFS_CTRL, 32'h2);
        @(posedge clock);
        offer <= 1'b1;
        offer_req <= mkreq(rows[8]);
        @(posedge clock);
        offer_req <= mkreq(rows[4]);
        @(posedge clock);
        offer_req <= mkreq(rows[5]);
        #1 chk("stall", {31'h0, req_ready}, 32'h0);
        @(posedge clock);
        #1 expect_res(rows[8]);
        @(posedge clock);
        offer <= 1'b0;
        #1 expect_res(rows[4]);
        @(posedge clock);
        #1 expect_res(rows[5]);
        $display("test back to back done");
        wr(`EAG_OFS_STATUS, 32'h7);
        wr(`EAG_OFS_MASK, 32'h2);
        run_row(rows[18]);
        @(posedge clock);
        #1 chk("irq raised", {31'h0, irq}, 32'h1);
        rd(`EAG_OFS_STATUS, v);
        chk("status", v, 32'h3);
        rd(`EAG_OFS_LAST_EA, v);
        chk("last ea", v, 32'h00010000);
        rd(`EAG_OFS_LAST_LIN, v);
        chk("last linear", v, 32'h00022340);
        wr(`EAG_OFS_STATUS, 32'h2);
        #1 chk("irq cleared", {31'h0, irq}, 32'h0);
        rd(`EAG_OFS_STATUS, v);
        chk("status", v, 32'h1);
        wr(`EAG_OFS_MASK, 32'h1);
        #1 chk("irq unmasked", {31'h0, irq}, 32'h1);
        $display("test interrupt done");
        @(posedge clock);
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        #1 chk("reset again", {29'h0, req_ready, res_valid, irq}, 32'h4);
        rd(`EAG_OFS_CTRL, v);
        chk("ctrl again", v, {30'h0, `EAG_CTRL_RESET});
        $display("test reset again done");
        results();
    end
endmodule
